// ==== hw/frt_timer_capture.sv ====
// Free-running 16-bit timer with two edge capture channels
`timescale 1ns/1ps
`default_nettype none

// Contract
// R01: A 16-bit counter counts up on each timer capture clock and software can read it.
// R02: The timer runs from its own clock, which is brought into the register clock domain.
// R03: Reading the low byte latches the high byte, and a later high-byte read returns the latched value.
// R04: A written low byte is held, and the whole counter loads only when the high byte is written.
// R05: Software accesses the low byte before the high byte for both reads and writes.
// R06: A periodic interrupt is raised once every 4096 counts, 1024 us at 4 MHz.
// R07: An interrupt can be raised when the counter wraps from its maximum to zero.
// R08: A rising edge on capture input 0 loads the channel-0 rise register, bits chosen by the select field in 8-bit mode.
// R09: A falling edge on capture input 0 loads the channel-0 fall register, bits chosen by the select field in 8-bit mode.
// R10: In 8-bit mode a rising edge on capture input 1 loads the selected bits into the channel-1 rise register.
// R11: In 8-bit mode a falling edge on capture input 1 loads the selected bits into the channel-1 fall register.
// R12: In 16-bit mode the channel-0 registers take the low counter byte on input-0 edges.
// R13: In 16-bit mode the channel-1 rise register takes the high counter byte on each input-0 rising edge.
// R14: In 16-bit mode the channel-1 fall register takes the high counter byte on each input-0 falling edge.
// R15: A configuration bit merges the two 8-bit channels into one 16-bit capture with channel 1 as high byte.
// R16: Each of the four capture registers has its own interrupt enable and raises its interrupt when loaded.
// R17: Both capture inputs are synchronised before edge detection so each edge gives exactly one capture; in 16-bit mode input-1 edges give none.
module frt_timer_capture (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              timer_capture_clock,
  input  wire logic              capture_input_0,
  input  wire logic              capture_input_1,
  input  wire frt_pkg::frt_addr_t reg_addr,
  input  wire frt_pkg::frt_data_t reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output frt_pkg::frt_data_t     reg_rdata,
  output logic                   irq
);

  import frt_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic hit(input frt_addr_t a, input frt_addr_t off);
    return a == off;
  endfunction : hit

  function automatic frt_data_t sel_bits(input frt_cnt_t c, input logic [SEL_W-1:0] s);
    frt_cnt_t sh;
    sh = c >> s;
    return sh[DATA_W-1:0];
  endfunction : sel_bits

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic tick;
  logic c0_rise;
  logic c0_fall;
  logic c1_rise;
  logic c1_fall;

  // Timer clock pin brought into the register domain
  frt_edge_sync u_tclk_sync ( // see R02
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin_in  (timer_capture_clock),
    .rise_o  (tick),
    .fall_o  ()
  );

  frt_edge_sync u_cap0_sync ( // see R17
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin_in  (capture_input_0),
    .rise_o  (c0_rise),
    .fall_o  (c0_fall)
  );

  frt_edge_sync u_cap1_sync ( // see R17
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin_in  (capture_input_1),
    .rise_o  (c1_rise),
    .fall_o  (c1_fall)
  );

  // ****************************************
  // Address decode
  // ****************************************
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic rd_high;
  logic rd_stat;
  logic wr_cfg;
  logic wr_mask;

  assign wr_low  = reg_wr && hit(reg_addr, CNT_LOW_OFF);
  assign wr_high = reg_wr && hit(reg_addr, CNT_HIGH_OFF);
  assign rd_low  = reg_rd && hit(reg_addr, CNT_LOW_OFF);
  assign rd_high = reg_rd && hit(reg_addr, CNT_HIGH_OFF);
  assign rd_stat = reg_rd && hit(reg_addr, STATUS_OFF);
  assign wr_cfg  = reg_wr && hit(reg_addr, CFG_OFF);
  assign wr_mask = reg_wr && hit(reg_addr, MASK_OFF);

  // ****************************************
  // Free-running counter
  // ****************************************
  frt_cnt_t  cnt_reg;
  frt_cnt_t  cnt_inc;
  frt_data_t low_buf_reg;
  frt_data_t hold_reg;

  assign cnt_inc = cnt_reg + CNT_ONE;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= CNT_RST;
    end else if (wr_high) begin
      cnt_reg <= {reg_wdata, low_buf_reg}; // see R04
    end else if (tick) begin
      cnt_reg <= cnt_inc; // see R01
    end
  end

  // Low byte held until the high byte arrives
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_buf_reg <= REG_RST;
    end else if (wr_low) begin
      low_buf_reg <= reg_wdata; // see R04
    end
  end

  // High byte frozen by a low-byte read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_reg <= REG_RST;
    end else if (rd_low) begin
      hold_reg <= cnt_reg[CNT_W-1:DATA_W]; // see R03
    end
  end

  // ****************************************
  // Configuration
  // ****************************************
  frt_cfg_s cfg_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg <= CFG_RST;
    end else if (wr_cfg) begin
      cfg_reg.wide <= reg_wdata[CFG_WIDE_BIT]; // see R15
      cfg_reg.sel  <= reg_wdata[CFG_SEL_LSB +: SEL_W];
    end
  end

  // ****************************************
  // Capture registers
  // ****************************************
  frt_data_t c0r_reg;
  frt_data_t c1r_reg;
  frt_data_t c0f_reg;
  frt_data_t c1f_reg;
  frt_data_t cap_lo;
  frt_data_t cap_hi;
  logic      ld_c0r;
  logic      ld_c1r;
  logic      ld_c0f;
  logic      ld_c1f;

  // Selected bits in 8-bit mode, low byte in 16-bit mode
  assign cap_lo = cfg_reg.wide ? cnt_reg[DATA_W-1:0] : sel_bits(cnt_reg, cfg_reg.sel); // see R08, R12
  assign cap_hi = cfg_reg.wide ? cnt_reg[CNT_W-1:DATA_W] : cap_lo; // see R15

  assign ld_c0r = c0_rise;
  assign ld_c0f = c0_fall;
  assign ld_c1r = cfg_reg.wide ? c0_rise : c1_rise; // see R13
  assign ld_c1f = cfg_reg.wide ? c0_fall : c1_fall; // see R14

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      c0r_reg <= REG_RST;
    end else if (ld_c0r) begin
      c0r_reg <= cap_lo; // see R08
    end else if (reg_wr && hit(reg_addr, C0_RISE_OFF)) begin
      c0r_reg <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      c0f_reg <= REG_RST;
    end else if (ld_c0f) begin
      c0f_reg <= cap_lo; // see R09
    end else if (reg_wr && hit(reg_addr, C0_FALL_OFF)) begin
      c0f_reg <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      c1r_reg <= REG_RST;
    end else if (ld_c1r) begin
      c1r_reg <= cap_hi; // see R10
    end else if (reg_wr && hit(reg_addr, C1_RISE_OFF)) begin
      c1r_reg <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      c1f_reg <= REG_RST;
    end else if (ld_c1f) begin
      c1f_reg <= cap_hi; // see R11
    end else if (reg_wr && hit(reg_addr, C1_FALL_OFF)) begin
      c1f_reg <= reg_wdata;
    end
  end

  // ****************************************
  // Events, status, mask and interrupt
  // ****************************************
  frt_stat_t ev;
  frt_stat_t status_reg;
  frt_stat_t status_next;
  frt_stat_t mask_reg;
  frt_stat_t mask_next;
  logic      irq_reg;

  always_comb begin
    ev = STAT_RST;
    ev[ST_PERIOD_BIT] = tick && !wr_high && ((cnt_inc & PERIOD_MASK) == CNT_RST); // see R06
    ev[ST_OVF_BIT]    = tick && !wr_high && (cnt_reg == CNT_MAX); // see R07
    ev[ST_C0R_BIT]    = ld_c0r; // see R16
    ev[ST_C1R_BIT]    = ld_c1r;
    ev[ST_C0F_BIT]    = ld_c0f;
    ev[ST_C1F_BIT]    = ld_c1f;
  end

  // Read clears, a new event in the same cycle survives
  always_comb begin
    status_next = (rd_stat ? STAT_RST : status_reg) | ev;
    mask_next   = wr_mask ? reg_wdata[STAT_W-1:0] : mask_reg;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= STAT_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= STAT_RST;
    end else begin
      mask_reg <= mask_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_next & mask_next); // see R16
    end
  end

  assign irq = irq_reg;

  // ****************************************
  // Read data
  // ****************************************
  frt_data_t rdata_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= REG_RST;
    end else if (!reg_rd) begin
      rdata_reg <= REG_RST;
    end else if (hit(reg_addr, CNT_LOW_OFF)) begin
      rdata_reg <= cnt_reg[DATA_W-1:0]; // see R01
    end else if (hit(reg_addr, CNT_HIGH_OFF)) begin
      rdata_reg <= hold_reg; // see R03
    end else if (hit(reg_addr, C0_RISE_OFF)) begin
      rdata_reg <= c0r_reg;
    end else if (hit(reg_addr, C1_RISE_OFF)) begin
      rdata_reg <= c1r_reg;
    end else if (hit(reg_addr, C0_FALL_OFF)) begin
      rdata_reg <= c0f_reg;
    end else if (hit(reg_addr, C1_FALL_OFF)) begin
      rdata_reg <= c1f_reg;
    end else if (hit(reg_addr, CFG_OFF)) begin
      rdata_reg <= {4'h0, cfg_reg.wide, cfg_reg.sel};
    end else if (hit(reg_addr, STATUS_OFF)) begin
      rdata_reg <= {2'h0, status_reg};
    end else if (hit(reg_addr, MASK_OFF)) begin
      rdata_reg <= {2'h0, mask_reg};
    end else begin
      rdata_reg <= REG_RST;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence rd_low_s;
    reg_rd && hit(reg_addr, CNT_LOW_OFF);
  endsequence
  sequence rd_high_s;
    reg_rd && hit(reg_addr, CNT_HIGH_OFF);
  endsequence
  sequence wr_low_s;
    reg_wr && hit(reg_addr, CNT_LOW_OFF);
  endsequence
  sequence wr_high_s;
    reg_wr && hit(reg_addr, CNT_HIGH_OFF);
  endsequence

  counter_tick_a: assert property (tick && !wr_high |=> cnt_reg == $past(cnt_inc)) // see R01
    else $error("counter did not advance on timer tick");
  counter_idle_a: assert property (!tick && !wr_high |=> $stable(cnt_reg)) // see R01
    else $error("counter moved without a tick");
  atomic_read_a: assert property (rd_low_s ##1 (!rd_low) [*2] ##0 rd_high_s |=> // see R03
                                  reg_rdata == $past(cnt_reg[CNT_W-1:DATA_W], 3))
    else $error("high byte read did not return value latched by low read");
  low_write_a: assert property (wr_low_s ##0 !tick |=> $stable(cnt_reg) && low_buf_reg == $past(reg_wdata)) // see R04
    else $error("low byte write changed the counter");
  high_write_a: assert property (wr_low_s ##1 (!reg_wr) [*1] ##1 wr_high_s |=> // see R04
                                 cnt_reg == {$past(reg_wdata), $past(reg_wdata, 3)})
    else $error("counter not loaded from buffered low and written high");
  periodic_flag_a: assert property (tick && !wr_high && cnt_reg[11:0] == 12'hfff |=> // see R06
                                    status_reg[ST_PERIOD_BIT])
    else $error("periodic flag missing after 4096 counts");
  overflow_wrap_a: assert property (tick && !wr_high && cnt_reg == CNT_MAX |=> // see R07
                                    cnt_reg == CNT_RST && status_reg[ST_OVF_BIT])
    else $error("wrap did not clear counter and set overflow flag");
  narrow_rise_a: assert property (c0_rise && !cfg_reg.wide |=> // see R08
                                  c0r_reg == sel_bits($past(cnt_reg), $past(cfg_reg.sel)))
    else $error("channel 0 rise capture holds wrong bits");
  narrow_fall_a: assert property (c1_fall && !cfg_reg.wide |=> // see R11
                                  c1f_reg == sel_bits($past(cnt_reg), $past(cfg_reg.sel)))
    else $error("channel 1 fall capture holds wrong bits");
  wide_rise_a: assert property (c0_rise && cfg_reg.wide |=> // see R13
                                {c1r_reg, c0r_reg} == $past(cnt_reg))
    else $error("16-bit rise capture mismatch");
  wide_fall_a: assert property (c0_fall && cfg_reg.wide |=> // see R14
                                {c1f_reg, c0f_reg} == $past(cnt_reg))
    else $error("16-bit fall capture mismatch");
  wide_ignore_a: assert property (cfg_reg.wide && c1_rise && !c0_rise && !reg_wr |=> $stable(c1r_reg)) // see R15
    else $error("input 1 edge loaded a capture in 16-bit mode");
  irq_level_a: assert property (irq == |(status_reg & mask_reg)) // see R16
    else $error("interrupt output disagrees with masked status");
  flag_set_wins_a: assert property (rd_stat && ld_c0r |=> status_reg[ST_C0R_BIT] ##1 // see R16
                                    (status_reg[ST_C0R_BIT] || $past(rd_stat)))
    else $error("capture flag lost when read in the same cycle");

endmodule : frt_timer_capture

`default_nettype wire

// ==== hw/frt_pkg.sv ====
// Package of constants and types for the free-running timer with capture
package frt_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 16;
  localparam int SEL_W  = 3;
  localparam int STAT_W = 6;

  typedef logic [ADDR_W-1:0] frt_addr_t;
  typedef logic [DATA_W-1:0] frt_data_t;
  typedef logic [CNT_W-1:0]  frt_cnt_t;
  typedef logic [STAT_W-1:0] frt_stat_t;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam frt_addr_t CNT_LOW_OFF   = 8'h20;
  localparam frt_addr_t CNT_HIGH_OFF  = 8'h21;
  localparam frt_addr_t C0_RISE_OFF   = 8'h22;
  localparam frt_addr_t C1_RISE_OFF   = 8'h23;
  localparam frt_addr_t C0_FALL_OFF   = 8'h24;
  localparam frt_addr_t C1_FALL_OFF   = 8'h25;
  localparam frt_addr_t CFG_OFF       = 8'h30;
  localparam frt_addr_t STATUS_OFF    = 8'h31;
  localparam frt_addr_t MASK_OFF      = 8'h32;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_SEL_LSB   = 0;
  localparam int CFG_WIDE_BIT  = 3;
  localparam int ST_PERIOD_BIT = 0;
  localparam int ST_OVF_BIT    = 1;
  localparam int ST_C0R_BIT    = 2;
  localparam int ST_C1R_BIT    = 3;
  localparam int ST_C0F_BIT    = 4;
  localparam int ST_C1F_BIT    = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam frt_data_t REG_RST  = 8'h00;
  localparam frt_cnt_t  CNT_RST  = 16'h0000;
  localparam frt_stat_t STAT_RST = 6'h00;

  // ****************************************
  // Periodic event spacing in timer counts
  // ****************************************
  localparam int PERIOD_US       = 1024;
  localparam int TIMER_REF_MHZ   = 4;
  localparam int PERIOD_COUNTS   = PERIOD_US * TIMER_REF_MHZ;
  localparam frt_cnt_t PERIOD_MASK = frt_cnt_t'(PERIOD_COUNTS - 1);
  localparam frt_cnt_t CNT_MAX     = 16'hffff;
  localparam frt_cnt_t CNT_ONE     = 16'h0001;

  // ****************************************
  // Capture configuration carrier
  // ****************************************
  typedef struct packed {
    logic             wide;
    logic [SEL_W-1:0] sel;
  } frt_cfg_s;

  localparam frt_cfg_s CFG_RST = '{wide: 1'b0, sel: 3'h0};

endpackage : frt_pkg

// ==== hw/frt_edge_sync.sv ====
// Two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none

module frt_edge_sync (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      rise_o,
  output logic      fall_o
);

  // ****************************************
  // Synchroniser and edge history
  // ****************************************
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // One pulse per edge
  assign rise_o = sync_reg & ~last_reg; // see R17
  assign fall_o = ~sync_reg & last_reg; // see R17

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence pin_up_s;
    !pin_in [*3] ##1 pin_in [*3];
  endsequence

  sequence pin_down_s;
    pin_in [*3] ##1 !pin_in [*3];
  endsequence

  sync_rise_edge_a: assert property (pin_up_s |-> rise_o ##1 !rise_o) // see R17
    else $error("rising pin edge did not give one pulse");
  sync_fall_edge_a: assert property (pin_down_s |-> fall_o ##1 !fall_o) // see R17
    else $error("falling pin edge did not give one pulse");

endmodule : frt_edge_sync

`default_nettype wire

// ==== testbench/frt_pin_model.sv ====
// Pin-side model: timer count clock and capture pins
`timescale 1ns/1ps
`default_nettype none

module frt_pin_model (
  input  wire logic ref_clk,
  input  wire logic tick_req,
  input  wire logic lvl0,
  input  wire logic lvl1,
  output logic      tclk,
  output logic      pin0,
  output logic      pin1
);
  logic [2:0] ph;

  initial begin
    ph   = 3'h0;
    tclk = 1'b0;
    pin0 = 1'b0;
    pin1 = 1'b0;
  end

  // ****************************************
  // Count clock, still between requests
  // ****************************************
  // High 3 cycles, low 4 cycles per count
  always @(posedge ref_clk) begin
    if (ph != 3'h0) begin
      ph   <= ph - 3'h1;
      tclk <= (ph - 3'h1) >= 3'h4;
    end else if (tick_req) begin
      ph   <= 3'h6;
      tclk <= 1'b1;
    end
  end

  // ****************************************
  // Capture pins
  // ****************************************
  always @(posedge ref_clk) begin
    pin0 <= lvl0;
    pin1 <= lvl1;
  end
endmodule : frt_pin_model
`default_nettype wire

// ==== testbench/free_running_timer_capture_tb.sv ====
// Self-checking bench of the timer with capture
`timescale 1ns/1ps
`default_nettype none

module free_running_timer_capture_tb;
  import frt_pkg::*;
  logic      ref_clk   = 1'b0;
  logic      rst_b     = 1'b0;
  logic      tick_req  = 1'b0;
  logic      lvl0      = 1'b0;
  logic      lvl1      = 1'b0;
  logic      reg_wr    = 1'b0;
  logic      reg_rd    = 1'b0;
  frt_addr_t reg_addr  = 8'h00;
  frt_data_t reg_wdata = 8'h00;
  wire logic tclk;
  wire logic pin0;
  wire logic pin1;
  wire logic irq;
  wire frt_data_t reg_rdata;
  int        mismatches = 0;
  int        n_compared = 0;
  int        cycles     = 0;
  logic [31:0] seed     = 32'h00001505;
  frt_cnt_t  v;
  frt_cnt_t  e;
  frt_data_t d;

  frt_timer_capture dut_u (
    .ref_clk             (ref_clk),
    .rst_b               (rst_b),
    .timer_capture_clock (tclk),
    .capture_input_0     (pin0),
    .capture_input_1     (pin1),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .irq                 (irq)
  );

  frt_pin_model pin_u (
    .ref_clk  (ref_clk),
    .tick_req (tick_req),
    .lvl0     (lvl0),
    .lvl1     (lvl1),
    .tclk     (tclk),
    .pin0     (pin0),
    .pin1     (pin1)
  );

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic frt_data_t sel8(input frt_cnt_t c, input int s);
    return frt_data_t'(c >> s);
  endfunction : sel8

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic chk(input frt_data_t got, input frt_data_t exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input frt_addr_t a, input frt_data_t dat);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= dat;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rdchk(input frt_addr_t a, input frt_data_t exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rdchk

  task automatic clr_status();
    @(posedge ref_clk);
    reg_addr <= STATUS_OFF;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
  endtask : clr_status

  task automatic setc(input frt_cnt_t c);
    wr(CNT_LOW_OFF, c[7:0]);
    wr(CNT_HIGH_OFF, c[15:8]);
  endtask : setc

  task automatic tick();
    @(posedge ref_clk);
    tick_req <= 1'b1;
    @(posedge ref_clk);
    tick_req <= 1'b0;
    cyc(10);
  endtask : tick

  task automatic edges();
    @(posedge ref_clk);
    lvl0 <= 1'b1;
    cyc(6);
    lvl0 <= 1'b0;
    cyc(6);
    lvl1 <= 1'b1;
    cyc(6);
    lvl1 <= 1'b0;
    cyc(6);
  endtask : edges

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cyc(2);
    rst_b <= 1'b1;
    for (int a = 'h20; a <= 'h25; a++) rdchk(frt_addr_t'(a), REG_RST);
    rdchk(CFG_OFF, REG_RST);
    rdchk(MASK_OFF, REG_RST);
    wr(8'h40, 8'hff);
    rdchk(8'h40, 8'h00);
    wr(STATUS_OFF, 8'h3f);
    rdchk(STATUS_OFF, 8'h00);
    // Counting from random loads
    for (int i = 0; i < 4; i++) begin
      v = frt_cnt_t'(rnd());
      e = v + frt_cnt_t'(rnd() % 5 + 1);
      setc(v);
      while (v != e) begin
        tick();
        v++;
      end
      rdchk(CNT_LOW_OFF, e[7:0]);
      rdchk(CNT_HIGH_OFF, e[15:8]);
    end
    // Low byte alone does not load
    wr(CNT_LOW_OFF, ~e[7:0]);
    rdchk(CNT_LOW_OFF, e[7:0]);
    wr(CNT_HIGH_OFF, 8'h12);
    rdchk(CNT_LOW_OFF, ~e[7:0]);
    rdchk(CNT_HIGH_OFF, 8'h12);
    // Held high byte across a carry
    setc(16'h12ff);
    rdchk(CNT_LOW_OFF, 8'hff);
    tick();
    rdchk(CNT_HIGH_OFF, 8'h12);
    rdchk(CNT_LOW_OFF, 8'h00);
    rdchk(CNT_HIGH_OFF, 8'h13);
    // Periodic and wrap events with mask
    clr_status();
    wr(MASK_OFF, 8'h01);
    setc(16'h0fff);
    tick();
    chk({7'h00, irq}, 8'h01);
    rdchk(STATUS_OFF, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    wr(MASK_OFF, 8'h02);
    setc(16'hfffe);
    tick();
    chk({7'h00, irq}, 8'h00);
    tick();
    chk({7'h00, irq}, 8'h01);
    rdchk(STATUS_OFF, 8'h03);
    // Eight-bit captures for every select value
    clr_status();
    for (int s = 0; s < 8; s++) begin
      v = frt_cnt_t'(rnd());
      setc(v);
      wr(CFG_OFF, frt_data_t'(s));
      edges();
      rdchk(C0_RISE_OFF, sel8(v, s));
      rdchk(C0_FALL_OFF, sel8(v, s));
      rdchk(C1_RISE_OFF, sel8(v, s));
      rdchk(C1_FALL_OFF, sel8(v, s));
      rdchk(STATUS_OFF, 8'h3c);
    end
    // Merged sixteen-bit capture
    wr(CFG_OFF, 8'h08);
    v = frt_cnt_t'(rnd());
    setc(v);
    edges();
    rdchk(C0_RISE_OFF, v[7:0]);
    rdchk(C0_FALL_OFF, v[7:0]);
    rdchk(C1_RISE_OFF, v[15:8]);
    rdchk(C1_FALL_OFF, v[15:8]);
    wr(C1_RISE_OFF, 8'h5a);
    rdchk(C1_RISE_OFF, 8'h5a);
    // Per-capture interrupt enable
    wr(CFG_OFF, 8'h00);
    clr_status();
    wr(MASK_OFF, 8'h08);
    @(posedge ref_clk);
    lvl0 <= 1'b1;
    cyc(2);
    rdchk(STATUS_OFF, 8'h00);
    cyc(4);
    chk({7'h00, irq}, 8'h00);
    lvl1 <= 1'b1;
    cyc(6);
    chk({7'h00, irq}, 8'h01);
    rdchk(STATUS_OFF, 8'h0c);
    // Reset in mid-run
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    rdchk(CNT_LOW_OFF, REG_RST);
    rdchk(MASK_OFF, REG_RST);
    chk({7'h00, irq}, 8'h00);
    report_and_stop();
  end
endmodule : free_running_timer_capture_tb
`default_nettype wire
